// >>> logic/cmmd_core_memory_map_decoder.v
// Core register file and data/program address decoder of an 8-bit core.
// Assumes the instruction datapath drives requests synchronous to clk;
// peripheral registers are answered by outside logic; general RAM offsets 0x20-0x6F are not decoded and read zero.
`timescale 1ns/1ps
`include "cmmd_defs.vh"

module cmmd_core_memory_map_decoder #(
  parameter PROG_WORDS_LOG2 = 15,
  parameter COMMON_BYTES = 16
) (
  input wire clk,
  input wire rst_n,
  input wire fetchAdvance,
  input wire irqTake,
  input wire branchRel,
  input wire jumpEn,
  input wire [14:0] jumpTarget,
  input wire retLit,
  input wire [7:0] retLitValue,
  input wire [14:0] retAddr,
  input wire accEn,
  input wire accWrite,
  input wire accIndirect,
  input wire accPtrSel,
  input wire [6:0] accOffset,
  input wire [7:0] accWdata,
  input wire [2:0] aluOp,
  input wire [7:0] aluA,
  input wire [7:0] aluB,
  input wire aluCarryIn,
  input wire watchdogClearInstr,
  input wire sleepInstr,
  input wire watchdogTimeout,
  input wire [13:0] progRdata,
  input wire [7:0] periphRdata,
  output reg [14:0] pcOut,
  output reg [14:0] progAddr,
  output reg progRd,
  output reg [7:0] accRdata,
  output reg accValid,
  output reg stallCycle,
  output reg [12:0] periphAddr,
  output reg periphSel,
  output reg periphWr,
  output reg [7:0] periphWdata,
  output reg [7:0] aluResult,
  output reg [7:0] statusOut
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rstMeta_reg;
  reg rstSync_reg;
  wire rstLocal_n = rstSync_reg;

  // Release reset only through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser for the watchdog timeout
  // ----------------------------------------------------------------
  reg [1:0] wdtSync_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtSync_reg <= 2'h0;
    end else begin
      wdtSync_reg <= {wdtSync_reg[0], watchdogTimeout};
    end
  end

  // ----------------------------------------------------------------
  // Core registers and common RAM
  // ----------------------------------------------------------------
  reg [7:0] pclLow_reg;
  reg [7:0] pcHighLatch_reg;
  reg [14:0] pc_reg;
  reg [7:0] status_reg;
  reg [7:0] ptr0Low_reg;
  reg [7:0] ptr0High_reg;
  reg [7:0] ptr1Low_reg;
  reg [7:0] ptr1High_reg;
  reg [7:0] bankSelect_reg;
  reg [7:0] working_reg;
  reg [7:0] intCtrl_reg;
  reg [7:0] common_reg [0:COMMON_BYTES-1];
  reg extraPending_reg;

  // Wrap a program address into the implemented space
  function [14:0] wrapProg;
    input [14:0] addr;
    begin
      wrapProg = addr & ((15'h7FFF >> (15 - PROG_WORDS_LOG2)));
    end
  endfunction

  // Zero test shared by every ALU op
  function isZero;
    input [7:0] v;
    begin
      isZero = (v == 8'h00);
    end
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  reg [15:0] ptrSel;
  reg progSpace;
  reg [12:0] dataAddr;
  reg [6:0] ofs;
  reg isCore;
  reg isPeri;
  reg isCommon;
  wire [3:0] comIdx = ofs[3:0];

  always @* begin
    ptrSel = accPtrSel ? {ptr1High_reg, ptr1Low_reg} : {ptr0High_reg, ptr0Low_reg};
    progSpace = accIndirect && ptrSel[`CMMD_PROG_SEL_BIT + 8];
    if (accIndirect) begin
      dataAddr = ptrSel[12:0];
    end else begin
      dataAddr = {bankSelect_reg[5:0], accOffset};
    end
    ofs = dataAddr[6:0];
    isCore = (ofs <= `CMMD_CORE_LAST);
    isPeri = (ofs >= `CMMD_PERI_FIRST) && (ofs <= `CMMD_PERI_LAST);
    isCommon = (ofs >= `CMMD_COMMON_FIRST);
  end

  // Core register read mux
  reg [7:0] coreRead;
  always @* begin
    case (ofs)
      `CMMD_OFS_PCL: coreRead = pclLow_reg;
      `CMMD_OFS_STATUS: coreRead = status_reg;
      `CMMD_OFS_P0L: coreRead = ptr0Low_reg;
      `CMMD_OFS_P0H: coreRead = ptr0High_reg;
      `CMMD_OFS_P1L: coreRead = ptr1Low_reg;
      `CMMD_OFS_P1H: coreRead = ptr1High_reg;
      `CMMD_OFS_BANK: coreRead = bankSelect_reg;
      `CMMD_OFS_WORKING_REG: coreRead = working_reg;
      `CMMD_OFS_PC_HIGH_LATCH: coreRead = pcHighLatch_reg;
      `CMMD_OFS_INTERRUPT_CONTROL: coreRead = intCtrl_reg;
      default: coreRead = 8'h00; // IND0 and IND1 reads give zero
    endcase
  end

  // ----------------------------------------------------------------
  // ALU flags
  // ----------------------------------------------------------------
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] res;
  reg cOut;
  reg dcOut;
  reg flagsTouched;
  reg arith;
  always @* begin
    if (aluOp == `CMMD_ALU_SUB) begin
      sum = {1'b0, aluA} + {1'b0, ~aluB} + 9'h001;
      nib = {1'b0, aluA[3:0]} + {1'b0, ~aluB[3:0]} + 5'h01;
    end else begin
      sum = {1'b0, aluA} + {1'b0, aluB};
      nib = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
    end
    arith = (aluOp == `CMMD_ALU_ADD) || (aluOp == `CMMD_ALU_SUB);
    res = aluA;
    cOut = status_reg[`CMMD_BIT_C];
    dcOut = status_reg[`CMMD_BIT_DC];
    case (aluOp)
      `CMMD_ALU_ADD, `CMMD_ALU_SUB: begin
        res = sum[7:0];
        cOut = sum[8];
        dcOut = nib[4];
      end
      `CMMD_ALU_LOGIC: res = aluA;
      `CMMD_ALU_RRF: begin
        res = {aluCarryIn, aluA[7:1]};
        cOut = aluA[0];
      end
      `CMMD_ALU_RLF: begin
        res = {aluA[6:0], aluCarryIn};
        cOut = aluA[7];
      end
      default: res = aluA;
    endcase
    flagsTouched = (aluOp != `CMMD_ALU_NONE);
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  wire doWrite = accEn && accWrite && !progSpace;
  integer i;

  always @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pc_reg <= `CMMD_RESET_VEC;
      status_reg <= `CMMD_STATUS_RST;
      pclLow_reg <= 8'h00;
      pcHighLatch_reg <= 8'h00;
      ptr0Low_reg <= 8'h00;
      ptr0High_reg <= 8'h00;
      ptr1Low_reg <= 8'h00;
      ptr1High_reg <= 8'h00;
      bankSelect_reg <= 8'h00;
      working_reg <= 8'h00;
      intCtrl_reg <= 8'h00;
      extraPending_reg <= 1'b0;
      for (i = 0; i < COMMON_BYTES; i = i + 1) begin
        common_reg[i] <= 8'h00;
      end
    end else begin
      if (irqTake) begin
        pc_reg <= `CMMD_INT_VEC;
      end else if (retLit) begin
        pc_reg <= wrapProg(retAddr);
      end else if (branchRel) begin
        pc_reg <= wrapProg(pc_reg + {7'h00, working_reg});
      end else if (jumpEn) begin
        pc_reg <= wrapProg(jumpTarget);
      end else if (fetchAdvance && !extraPending_reg) begin
        pc_reg <= wrapProg(pc_reg + 15'h0001);
      end
      // one extra cycle for program-space access
      extraPending_reg <= accEn && progSpace && !extraPending_reg;
      if (retLit) begin
        working_reg <= retLitValue;
      end
      if (doWrite && isCore) begin
        case (ofs)
          `CMMD_OFS_PCL: pclLow_reg <= accWdata;
          `CMMD_OFS_P0L: ptr0Low_reg <= accWdata;
          `CMMD_OFS_P0H: ptr0High_reg <= accWdata;
          `CMMD_OFS_P1L: ptr1Low_reg <= accWdata;
          `CMMD_OFS_P1H: ptr1High_reg <= accWdata;
          // 32 banks need five bank bits
          `CMMD_OFS_BANK: bankSelect_reg <= {3'h0, accWdata[4:0]};
          `CMMD_OFS_WORKING_REG: working_reg <= accWdata;
          `CMMD_OFS_PC_HIGH_LATCH: pcHighLatch_reg <= accWdata;
          `CMMD_OFS_INTERRUPT_CONTROL: intCtrl_reg <= accWdata;
          default: pclLow_reg <= pclLow_reg;
        endcase
      end
      if (doWrite && isCommon) begin
        common_reg[comIdx] <= accWdata;
      end
      // Status: instruction write only when no ALU op updates the flags
      if (doWrite && isCore && (ofs == `CMMD_OFS_STATUS) && !flagsTouched) begin
        status_reg[2:0] <= accWdata[2:0];
      end
      if (flagsTouched) begin
        status_reg[`CMMD_BIT_Z] <= isZero(res);
        if (arith || aluOp == `CMMD_ALU_RRF || aluOp == `CMMD_ALU_RLF) begin
          status_reg[`CMMD_BIT_C] <= cOut;
        end
        if (arith) begin
          status_reg[`CMMD_BIT_DC] <= dcOut;
        end
      end
      if (wdtSync_reg[1]) begin
        status_reg[`CMMD_BIT_TO] <= 1'b0;
      end else if (watchdogClearInstr || sleepInstr) begin
        status_reg[`CMMD_BIT_TO] <= 1'b1;
      end
      if (sleepInstr) begin
        status_reg[`CMMD_BIT_PD] <= 1'b0;
      end else if (watchdogClearInstr) begin
        status_reg[`CMMD_BIT_PD] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pcOut <= `CMMD_RESET_VEC;
      progAddr <= 15'h0000;
      progRd <= 1'b0;
      accRdata <= 8'h00;
      accValid <= 1'b0;
      stallCycle <= 1'b0;
      periphAddr <= 13'h0000;
      periphSel <= 1'b0;
      periphWr <= 1'b0;
      periphWdata <= 8'h00;
      aluResult <= 8'h00;
      statusOut <= `CMMD_STATUS_RST;
    end else begin
      pcOut <= pc_reg;
      aluResult <= res;
      statusOut <= status_reg;
      progRd <= accEn && progSpace && !extraPending_reg;
      progAddr <= wrapProg(ptrSel[14:0]);
      stallCycle <= accEn && progSpace && !extraPending_reg;
      periphSel <= accEn && !progSpace && isPeri;
      periphWr <= doWrite && isPeri;
      periphAddr <= dataAddr;
      periphWdata <= accWdata;
      accValid <= (accEn && !progSpace) || extraPending_reg;
      if (extraPending_reg) begin
        accRdata <= progRdata[7:0];
      end else if (isCore) begin
        accRdata <= coreRead;
      end else if (isPeri) begin
        accRdata <= periphRdata;
      end else if (isCommon) begin
        accRdata <= common_reg[comIdx];
      end else begin
        accRdata <= 8'h00;
      end
    end
  end

endmodule // cmmd_core_memory_map_decoder

// >>> logic/cmmd_defs.vh
// Constants for the core memory map decoder: core register offsets,
// status field positions, region bounds and vectors.
// Assumes inclusion by bare name from design files only.
`ifndef CMMD_DEFS_VH
`define CMMD_DEFS_VH
`define CMMD_OFS_IND0 7'h00
`define CMMD_OFS_IND1 7'h01
`define CMMD_OFS_PCL 7'h02
`define CMMD_OFS_STATUS 7'h03
`define CMMD_OFS_P0L 7'h04
`define CMMD_OFS_P0H 7'h05
`define CMMD_OFS_P1L 7'h06
`define CMMD_OFS_P1H 7'h07
`define CMMD_OFS_BANK 7'h08
`define CMMD_OFS_WORKING_REG 7'h09
`define CMMD_OFS_PC_HIGH_LATCH 7'h0A
`define CMMD_OFS_INTERRUPT_CONTROL 7'h0B
`define CMMD_CORE_LAST 7'h0B
`define CMMD_PERI_FIRST 7'h0C
`define CMMD_PERI_LAST 7'h1F
`define CMMD_COMMON_FIRST 7'h70
`define CMMD_RESET_VEC 15'h0000
`define CMMD_INT_VEC 15'h0004
`define CMMD_BIT_TO 4
`define CMMD_BIT_PD 3
`define CMMD_BIT_Z 2
`define CMMD_BIT_DC 1
`define CMMD_BIT_C 0
`define CMMD_PROG_SEL_BIT 7
`define CMMD_STATUS_RST 8'h18
`define CMMD_ALU_ADD 3'h0
`define CMMD_ALU_SUB 3'h1
`define CMMD_ALU_LOGIC 3'h2
`define CMMD_ALU_RRF 3'h3
`define CMMD_ALU_RLF 3'h4
`define CMMD_ALU_NONE 3'h7
`endif

// >>> verification/cmmd_asserts.sv
// Checker for the decoder: port-level timing of PC, status and fetches.
// Assumes a bind into the decoder top with ports matched by name.
`timescale 1ns/1ps
module cmmd_asserts (
  input wire clk,
  input wire rst_n,
  input wire irqTake,
  input wire jumpEn,
  input wire retLit,
  input wire [14:0] retAddr,
  input wire [2:0] aluOp,
  input wire [7:0] aluA,
  input wire [7:0] aluB,
  input wire watchdogClearInstr,
  input wire sleepInstr,
  input wire watchdogTimeout,
  input wire [13:0] progRdata,
  input wire progRd,
  input wire stallCycle,
  input wire accValid,
  input wire [7:0] accRdata,
  input wire [14:0] pcOut,
  input wire [7:0] aluResult,
  input wire [7:0] statusOut
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_state: assert property ($rose(rst_n) |-> statusOut == 8'h18 && pcOut == 15'h0000)
    else $error("reset state wrong");
  // Outputs copy internal state one edge later, so PC and status lag two edges
  a_irq_vector: assert property (irqTake |-> ##2 pcOut == 15'h0004)
    else $error("interrupt vector wrong");
  a_ret_literal: assert property (retLit && !irqTake |-> ##2 pcOut == $past(retAddr, 2))
    else $error("literal return address wrong");
  // Synchroniser delay means a timeout may land several edges late
  a_flag_source: assert property (!$stable(statusOut[4:3]) |-> $past(sleepInstr, 2) ||
    $past(watchdogClearInstr, 2) || $past(watchdogTimeout, 2) || $past(watchdogTimeout, 3) ||
    $past(watchdogTimeout, 4)) else $error("read-only flags changed");
  a_sleep_flags: assert property (sleepInstr && !watchdogTimeout |-> ##2 statusOut[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_clear_flags: assert property (watchdogClearInstr && !sleepInstr |-> ##2 statusOut[4:3] == 2'b11)
    else $error("watchdog clear flags wrong");
  a_prog_fetch: assert property (progRd |-> stallCycle ##1
    (accValid && accRdata == $past(progRdata[7:0]))) else $error("program read wrong");
  a_add_carry: assert property (aluOp == 3'h0 |-> ##2
    {statusOut[0], $past(aluResult)} == {1'b0, $past(aluA, 2)} + {1'b0, $past(aluB, 2)})
    else $error("add carry wrong");
  a_sub_borrow: assert property (aluOp == 3'h1 |-> ##2
    {statusOut[0], $past(aluResult)} == {1'b0, $past(aluA, 2)} + {1'b0, ~$past(aluB, 2)} + 9'h001)
    else $error("subtract borrow wrong");
  a_zero_flag: assert property (aluOp == 3'h0 || aluOp == 3'h1 |-> ##2
    statusOut[2] == ($past(aluResult) == 8'h00)) else $error("zero flag wrong");
endmodule // cmmd_asserts

// >>> verification/cmmd_far_model.sv
// Far-side model: program memory words and a peripheral read responder.
// Assumes combinational answers; idle buses show an inverted pattern.
`timescale 1ns/1ps
module cmmd_far_model (
  input wire [14:0] progAddr,
  input wire progRd,
  input wire [12:0] periphAddr,
  input wire periphSel,
  output logic [13:0] progRdata,
  output logic [7:0] periphRdata
);
  // ----
  // Answers
  // ----
  logic [13:0] word;
  // Inverted when idle so a stale sample never passes for a fresh one
  assign word = {progAddr[5:0], progAddr[7:0] ^ 8'h5A};
  assign progRdata = progRd ? word : ~word;
  assign periphRdata = periphSel ? periphAddr[7:0] ^ 8'hC3 : ~periphAddr[7:0];
endmodule // cmmd_far_model

// >>> verification/cmmd_core_memory_map_decoder_bench.sv
// Testbench for the decoder: directed PC, ALU, status and access sequences.
// Assumes the far model supplies program words and peripheral data.
`timescale 1ns/1ps
module cmmd_core_memory_map_decoder_bench;
  logic clk = 0, rst_n = 0, fetchAdvance = 0, irqTake = 0, branchRel = 0, jumpEn = 0;
  logic retLit = 0, accEn = 0, accWrite = 0, accIndirect = 0, accPtrSel = 0, aluCarryIn = 0;
  logic watchdogClearInstr = 0, sleepInstr = 0, watchdogTimeout = 0;
  logic [14:0] jumpTarget = 0, retAddr = 0;
  logic [7:0] retLitValue = 0, accWdata = 0, aluA = 0, aluB = 0, rd;
  logic [6:0] accOffset = 0;
  logic [2:0] aluOp = 3'h7;
  wire [14:0] pcOut, progAddr;
  wire [13:0] progRdata;
  wire [12:0] periphAddr;
  wire [7:0] periphRdata, accRdata, periphWdata, aluResult, statusOut;
  wire progRd, accValid, stallCycle, periphSel, periphWr;
  int miscompares = 0, comparisons = 0;
  cmmd_core_memory_map_decoder u_dut (.*);
  cmmd_far_model u_far (.*);
  // ----
  // Tasks
  // ----
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // PC output trails the counter by one edge
  task automatic pcChk(input logic [14:0] exp);
    @(posedge clk);
    #1 chk(pcOut, exp);
  endtask
  // One access; a read that never answers ends the run
  task automatic acc(input logic [1:0] md, input logic [6:0] ofs, input logic [7:0] wd,
      input logic w, input logic [2:0] op);
    int i;
    @(posedge clk);
    accEn <= 1'b1;
    accWrite <= w;
    accIndirect <= md[0];
    accPtrSel <= md[1];
    accOffset <= ofs;
    accWdata <= wd;
    aluOp <= op;
    @(posedge clk);
    accEn <= 1'b0;
    aluOp <= 3'h7;
    for (i = 0; i < 4; i++) begin
      #1;
      if (accValid === 1'b1) begin
        rd = accRdata;
        return;
      end
      @(posedge clk);
    end
    if (!w) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic put(input logic [6:0] ofs, input logic [7:0] d);
    acc(2'b00, ofs, d, 1'b1, 3'h7);
  endtask
  task automatic rdc(input logic [1:0] md, input logic [6:0] ofs, input logic [7:0] exp);
    acc(md, ofs, 8'h00, 1'b0, 3'h7);
    chk(rd, exp);
  endtask
  task automatic alu(input logic [2:0] op, input logic [7:0] a, b, input logic ci,
      input logic [7:0] er, input logic [2:0] ef);
    @(posedge clk);
    aluOp <= op;
    aluA <= a;
    aluB <= b;
    aluCarryIn <= ci;
    @(posedge clk);
    aluOp <= 3'h7;
    #1;
    chk(aluResult, er);
    @(posedge clk);
    #1 chk(statusOut[2:0], ef);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(pcOut, 15'h0000);
    chk(statusOut, 8'h18);
    @(posedge clk) fetchAdvance <= 1'b1;
    repeat (3) @(posedge clk);
    fetchAdvance <= 1'b0;
    pcChk(15'h0003);
    @(posedge clk) irqTake <= 1'b1;
    @(posedge clk) irqTake <= 1'b0;
    pcChk(15'h0004);
    // Top of the program space then one step: must wrap to zero
    @(posedge clk);
    jumpTarget <= 15'h7FFF;
    jumpEn <= 1'b1;
    @(posedge clk);
    jumpEn <= 1'b0;
    fetchAdvance <= 1'b1;
    @(posedge clk) fetchAdvance <= 1'b0;
    #1 chk(pcOut, 15'h7FFF);
    pcChk(15'h0000);
    put(7'h09, 8'h05);
    @(posedge clk) branchRel <= 1'b1;
    @(posedge clk) branchRel <= 1'b0;
    pcChk(15'h0005);
    @(posedge clk);
    retLitValue <= 8'h3C;
    retAddr <= 15'h0123;
    retLit <= 1'b1;
    @(posedge clk) retLit <= 1'b0;
    pcChk(15'h0123);
    rdc(2'b00, 7'h09, 8'h3C);
    alu(3'h0, 8'h0F, 8'h01, 1'b0, 8'h10, 3'b010);
    alu(3'h0, 8'hF0, 8'h10, 1'b0, 8'h00, 3'b101);
    alu(3'h1, 8'h05, 8'h05, 1'b0, 8'h00, 3'b111);
    alu(3'h1, 8'h00, 8'h01, 1'b0, 8'hFF, 3'b000);
    alu(3'h3, 8'h03, 8'h00, 1'b1, 8'h81, 3'b001);
    alu(3'h4, 8'h41, 8'h00, 1'b0, 8'h82, 3'b000);
    put(7'h03, 8'hE7);
    rdc(2'b00, 7'h03, 8'h1F);
    aluA <= 8'h0F;
    aluB <= 8'h01;
    acc(2'b00, 7'h03, 8'h00, 1'b1, 3'h0);
    @(posedge clk);
    #1 chk(statusOut, 8'h1A);
    @(posedge clk) watchdogTimeout <= 1'b1;
    @(posedge clk) watchdogTimeout <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(statusOut[4:3], 2'b01);
    @(posedge clk) sleepInstr <= 1'b1;
    @(posedge clk) sleepInstr <= 1'b0;
    @(posedge clk);
    #1 chk(statusOut[4:3], 2'b10);
    @(posedge clk) watchdogClearInstr <= 1'b1;
    @(posedge clk) watchdogClearInstr <= 1'b0;
    @(posedge clk);
    #1 chk(statusOut[4:3], 2'b11);
    // Banks: five bank bits, shared RAM written from bank 0x1F and read back from bank 5
    put(7'h08, 8'hFF);
    rdc(2'b00, 7'h08, 8'h1F);
    put(7'h70, 8'hA5);
    put(7'h08, 8'h05);
    rdc(2'b00, 7'h70, 8'hA5);
    rdc(2'b00, 7'h08, 8'h05);
    acc(2'b00, 7'h20, 8'h00, 1'b0, 3'h7);
    chk(periphAddr, 13'h02A0);
    acc(2'b00, 7'h0C, 8'h00, 1'b0, 3'h7);
    chk(periphAddr, 13'h028C);
    put(7'h05, 8'h80);
    put(7'h04, 8'h12);
    rdc(2'b01, 7'h00, 8'h48);
    put(7'h07, 8'h80);
    put(7'h06, 8'h34);
    rdc(2'b11, 7'h00, 8'h6E);
    complete_run();
  end
endmodule // cmmd_core_memory_map_decoder_bench

bind cmmd_core_memory_map_decoder cmmd_asserts u_chk (.*);
